// ### pkg/csw_pkg.sv
package csw_pkg;

	// ------------------------------------------------------------
	// timing base
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4; // system clock period
	localparam int TICK_PERIOD_US = 1000; // shared time-base tick
	localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS; // clocks per tick
	localparam int PRE_W = 18; // prescaler width, holds tick_cycles
	localparam int RESET_HOLD_MS = 250; // reset hold after supply recovery, watchdog expiry or held-button release
	localparam int DEBOUNCE_MS = 250; // pushbutton debounce
	localparam int WD_SHORT_MS = 250; // watchdog period, select 01
	localparam int WD_MID_MS = 500; // watchdog period, select 10
	localparam int WD_LONG_MS = 1000; // watchdog period, select 11
	localparam int RESET_HOLD_TICKS = RESET_HOLD_MS * 1000 / TICK_PERIOD_US;
	localparam int DEBOUNCE_TICKS = DEBOUNCE_MS * 1000 / TICK_PERIOD_US;
	localparam int WD_SHORT_TICKS = WD_SHORT_MS * 1000 / TICK_PERIOD_US;
	localparam int WD_MID_TICKS = WD_MID_MS * 1000 / TICK_PERIOD_US;
	localparam int WD_LONG_TICKS = WD_LONG_MS * 1000 / TICK_PERIOD_US;
	localparam int CNT_W = 10; // tick counter width

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_REG_OFFSET = 8'h0B; // control register
	localparam logic [7:0] WD_REG_OFFSET = 8'h0D; // watchdog_period_select
	localparam int TD_LSB = 0; // timeout_select position
	localparam int OSC_DIS_BIT = 7; // osc_disable_n position
	localparam logic [1:0] TD_RST = 2'h3; // power-up: enabled, longest period
	localparam logic OSC_DIS_RST = 1'b1; // power-up: oscillator stops in backup
	localparam logic [1:0] TD_OFF = 2'h0; // watchdog disabled
	localparam logic [1:0] TD_SHORT = 2'h1;
	localparam logic [1:0] TD_MID = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic wr; // one-cycle write strobe
		logic [7:0] addr; // register offset
		logic [7:0] wdata; // write data
	} csw_reg_req_t;

	typedef enum logic [6:0] {
		ST_PWR_FAIL = 7'h01, // supply out of tolerance
		ST_OSC_WAIT = 7'h02, // waiting for oscillator start
		ST_HOLD = 7'h04, // fixed reset hold
		ST_RUN = 7'h08, // reset released, monitoring
		ST_DEBOUNCE = 7'h10, // pushbutton debounce, line pulled low
		ST_CHECK = 7'h20, // line released, let it settle
		ST_WAIT_REL = 7'h40 // waiting for button release
	} csw_state_t;

endpackage : csw_pkg

// ### core/csw_supervisor.sv
`timescale 1ns/1ns
// Notes on behaviour
// - supply out of tolerance drives reset low
// - hold reset 250 ms after supply recovers
// - oscillator stopped: hold also covers oscillator start
// - watch line for falling edge outside reset
// - on button edge pull line low 250 ms
// - still low: await release, then hold 250 ms
// - missed strobe within period asserts reset
// - select 00 off, 01/10/11 = 250/500/1000 ms
// - watchdog counts once reset goes inactive
// - power-up default: enabled, 1000 ms
// - strobe falling edge restarts full period
// - watchdog expiry holds reset 250 ms
// - period register bits 7..2 read zero
// - osc_disable_n one stops backup oscillator
module csw_supervisor #(
	parameter int TICK_CYC = csw_pkg::TICK_CYCLES,
	parameter int HOLD_TICKS = csw_pkg::RESET_HOLD_TICKS,
	parameter int DEB_TICKS = csw_pkg::DEBOUNCE_TICKS,
	parameter int WD_T1 = csw_pkg::WD_SHORT_TICKS,
	parameter int WD_T2 = csw_pkg::WD_MID_TICKS,
	parameter int WD_T3 = csw_pkg::WD_LONG_TICKS
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic supply_ok_in,
	input wire logic osc_ready_in,
	input wire logic watchdog_strobe_n_in,
	input wire logic rst_line_in,
	output logic rst_line_out,
	output logic rst_line_oe_n_out,
	input wire csw_pkg::csw_reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	output logic osc_run_out,
	output logic reset_active_out
);

	// ------------------------------------------------------------
	// state and registers
	// ------------------------------------------------------------
	csw_pkg::csw_state_t st_q; // supervisor state
	csw_pkg::csw_state_t st_d; // next state
	logic [csw_pkg::PRE_W-1:0] pre_q; // tick prescaler
	logic tick_q; // one-cycle tick pulse
	logic [csw_pkg::CNT_W-1:0] cnt_q; // ticks spent in state
	logic [csw_pkg::CNT_W-1:0] wd_cnt_q; // watchdog ticks left
	logic [csw_pkg::CNT_W-1:0] wd_period; // reload for current select
	logic [1:0] td_q; // timeout_select
	logic osc_dis_q; // osc_disable_n
	logic osc_stopped_q; // oscillator stopped during backup
	logic line_prev_q; // previous line sample
	logic strobe_prev_q; // previous strobe sample
	logic line_fall; // pushbutton press seen
	logic line_rise; // pushbutton release seen
	logic strobe_fall; // watchdog kick
	logic wd_write; // period register written
	logic wd_wr_q; // period write seen last cycle, new select in place
	logic drive_low; // pull the line next cycle
	logic [csw_pkg::CNT_W-1:0] hold_last; // last tick of hold
	logic [csw_pkg::CNT_W-1:0] deb_last; // last tick of debounce

	assign hold_last = csw_pkg::CNT_W'(HOLD_TICKS - 1);
	assign deb_last = csw_pkg::CNT_W'(DEB_TICKS - 1);
	assign line_fall = line_prev_q && !rst_line_in;
	assign line_rise = !line_prev_q && rst_line_in;
	assign strobe_fall = strobe_prev_q && !watchdog_strobe_n_in;
	assign wd_write = reg_req_in.wr && (reg_req_in.addr == csw_pkg::WD_REG_OFFSET);

	// ------------------------------------------------------------
	// time base
	// ------------------------------------------------------------

	// prescaler makes the shared tick for every interval
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pre_q <= '0;
			tick_q <= 1'b0;
		end else if (ce_in) begin
			if (pre_q == csw_pkg::PRE_W'(TICK_CYC - 1)) begin
				pre_q <= '0;
				tick_q <= 1'b1;
			end else begin
				pre_q <= pre_q + 1'b1;
				tick_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------

	// writable controls, power-up defaults
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			td_q <= csw_pkg::TD_RST;
			osc_dis_q <= csw_pkg::OSC_DIS_RST;
		end else if (ce_in && reg_req_in.wr) begin
			// upper period bits are not stored
			if (reg_req_in.addr == csw_pkg::WD_REG_OFFSET) begin
				td_q <= reg_req_in.wdata[csw_pkg::TD_LSB +: 2];
			end else if (reg_req_in.addr == csw_pkg::CTRL_REG_OFFSET) begin
				osc_dis_q <= reg_req_in.wdata[csw_pkg::OSC_DIS_BIT];
			end
		end
	end

	// registered read port
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 8'h00;
		end else if (ce_in) begin
			if (reg_req_in.addr == csw_pkg::WD_REG_OFFSET) begin
				reg_rdata_out <= {6'h00, td_q};
			end else if (reg_req_in.addr == csw_pkg::CTRL_REG_OFFSET) begin
				reg_rdata_out <= {osc_dis_q, 7'h00};
			end else begin
				reg_rdata_out <= 8'h00; // other offsets live elsewhere
			end
		end
	end

	// ------------------------------------------------------------
	// oscillator control
	// ------------------------------------------------------------

	// oscillator runs on supply, or in backup unless disabled
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			osc_run_out <= 1'b1;
			osc_stopped_q <= 1'b0;
		end else if (ce_in) begin
			osc_run_out <= supply_ok_in || !osc_dis_q;
			if (!supply_ok_in && osc_dis_q) begin
				osc_stopped_q <= 1'b1; // set wins over clear
			end else if (st_q == csw_pkg::ST_OSC_WAIT && osc_ready_in) begin
				osc_stopped_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------

	// previous samples for edge detection
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			line_prev_q <= 1'b1;
			strobe_prev_q <= 1'b1;
		end else if (ce_in) begin
			line_prev_q <= rst_line_in; // pin sampled apart from drive
			strobe_prev_q <= watchdog_strobe_n_in;
		end
	end

	// ------------------------------------------------------------
	// supervisor state machine
	// ------------------------------------------------------------

	// next-state logic, supply failure overrides all
	always_comb begin
		st_d = st_q;
		case (st_q)
			csw_pkg::ST_PWR_FAIL: begin
				if (supply_ok_in) begin
					st_d = osc_stopped_q ? csw_pkg::ST_OSC_WAIT : csw_pkg::ST_HOLD;
				end
			end
			csw_pkg::ST_OSC_WAIT: begin
				if (osc_ready_in) begin
					st_d = csw_pkg::ST_HOLD;
				end
			end
			csw_pkg::ST_HOLD: begin
				if (tick_q && cnt_q == hold_last) begin
					st_d = csw_pkg::ST_RUN;
				end
			end
			csw_pkg::ST_RUN: begin
				if (line_fall) begin
					st_d = csw_pkg::ST_DEBOUNCE;
				end else if (td_q != csw_pkg::TD_OFF && wd_cnt_q == '0 && tick_q) begin
					st_d = csw_pkg::ST_HOLD;
				end
			end
			csw_pkg::ST_DEBOUNCE: begin
				if (tick_q && cnt_q == deb_last) begin
					st_d = csw_pkg::ST_CHECK;
				end
			end
			csw_pkg::ST_CHECK: begin
				// one settle cycle after release, then look
				if (cnt_q != '0) begin
					st_d = rst_line_in ? csw_pkg::ST_RUN : csw_pkg::ST_WAIT_REL;
				end
			end
			csw_pkg::ST_WAIT_REL: begin
				if (line_rise) begin
					st_d = csw_pkg::ST_HOLD;
				end
			end
			default: st_d = csw_pkg::ST_PWR_FAIL;
		endcase
		if (!supply_ok_in) begin
			st_d = csw_pkg::ST_PWR_FAIL;
		end
	end

	// state register, power-up starts in the failed state
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_q <= csw_pkg::ST_PWR_FAIL;
		end else if (ce_in) begin
			st_q <= st_d;
		end
	end

	// interval counter, cleared on every state change
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_q <= '0;
		end else if (ce_in) begin
			if (st_d != st_q) begin
				cnt_q <= '0;
			end else if (st_q == csw_pkg::ST_CHECK) begin
				cnt_q <= csw_pkg::CNT_W'(1); // settle marker
			end else if (tick_q && cnt_q != '1) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------

	// period from timeout_select
	always_comb begin
		case (td_q)
			csw_pkg::TD_SHORT: wd_period = csw_pkg::CNT_W'(WD_T1);
			csw_pkg::TD_MID: wd_period = csw_pkg::CNT_W'(WD_T2);
			default: wd_period = csw_pkg::CNT_W'(WD_T3);
		endcase
	end

	// delayed write flag, so the reload sees the newly written select
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wd_wr_q <= 1'b0;
		end else if (ce_in) begin
			wd_wr_q <= wd_write;
		end
	end

	// countdown only while reset is inactive
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wd_cnt_q <= csw_pkg::CNT_W'(WD_T3);
		end else if (ce_in) begin
			if (st_q != csw_pkg::ST_RUN || strobe_fall || wd_wr_q) begin
				wd_cnt_q <= wd_period;
			end else if (tick_q && wd_cnt_q != '0 && td_q != csw_pkg::TD_OFF) begin
				wd_cnt_q <= wd_cnt_q - 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// reset line drive
	// ------------------------------------------------------------

	assign drive_low = !supply_ok_in || (st_d != csw_pkg::ST_RUN && st_d != csw_pkg::ST_CHECK
		&& st_d != csw_pkg::ST_WAIT_REL);

	// open-drain: level is fixed low, only enable moves
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_line_out <= 1'b0;
			rst_line_oe_n_out <= 1'b0;
			reset_active_out <= 1'b1;
		end else if (ce_in) begin
			rst_line_out <= 1'b0;
			rst_line_oe_n_out <= !drive_low;
			reset_active_out <= drive_low;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------

	sequence s_press;
		ce_in && supply_ok_in && st_q == csw_pkg::ST_RUN && line_fall;
	endsequence

	sequence s_debounce_entered;
		st_q == csw_pkg::ST_DEBOUNCE && !rst_line_oe_n_out;
	endsequence

	property p_fail_drives;
		@(posedge clk_in) disable iff (!resetn_in)
		ce_in && !supply_ok_in |=> !rst_line_oe_n_out && st_q == csw_pkg::ST_PWR_FAIL;
	endproperty
	a_fail_drives: assert property (p_fail_drives) else $error("supply fail not driving");

	property p_hold_bound;
		@(posedge clk_in) disable iff (!resetn_in)
		st_q == csw_pkg::ST_HOLD |-> cnt_q < csw_pkg::CNT_W'(HOLD_TICKS) && !rst_line_oe_n_out;
	endproperty
	a_hold_bound: assert property (p_hold_bound) else $error("hold too long");

	property p_osc_wait;
		@(posedge clk_in) disable iff (!resetn_in)
		ce_in && supply_ok_in && st_q == csw_pkg::ST_OSC_WAIT && !osc_ready_in
			|=> st_q == csw_pkg::ST_OSC_WAIT;
	endproperty
	a_osc_wait: assert property (p_osc_wait) else $error("left before osc start");

	property p_press;
		@(posedge clk_in) disable iff (!resetn_in)
		s_press ##1 ce_in |=> s_debounce_entered;
	endproperty
	a_press: assert property (p_press) else $error("press not debounced");

	property p_release;
		@(posedge clk_in) disable iff (!resetn_in)
		ce_in && supply_ok_in && st_q == csw_pkg::ST_WAIT_REL && line_rise
			|=> st_q == csw_pkg::ST_HOLD;
	endproperty
	a_release: assert property (p_release) else $error("release not held");

	property p_expire;
		@(posedge clk_in) disable iff (!resetn_in)
		ce_in && supply_ok_in && st_q == csw_pkg::ST_RUN && !line_fall && tick_q
			&& td_q != csw_pkg::TD_OFF && wd_cnt_q == '0 |=> st_q == csw_pkg::ST_HOLD;
	endproperty
	a_expire: assert property (p_expire) else $error("watchdog expiry missed");

	property p_kick;
		@(posedge clk_in) disable iff (!resetn_in)
		ce_in && strobe_fall |=> wd_cnt_q == $past(wd_period);
	endproperty
	a_kick: assert property (p_kick) else $error("kick did not reload");

	property p_upper_zero;
		@(posedge clk_in) disable iff (!resetn_in)
		$past(resetn_in) && $past(ce_in) && $past(reg_req_in.addr) == csw_pkg::WD_REG_OFFSET
			|-> reg_rdata_out[7:2] == 6'h00 && reg_rdata_out[1:0] == $past(td_q);
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("period reg readback wrong");

	property p_never_high;
		@(posedge clk_in) disable iff (!resetn_in)
		st_q == csw_pkg::ST_RUN && $past(st_q) == csw_pkg::ST_RUN
			&& $past(ce_in) && $past(supply_ok_in) |-> rst_line_out == 1'b0 && rst_line_oe_n_out;
	endproperty
	a_never_high: assert property (p_never_high) else $error("line driven wrongly");

endmodule : csw_supervisor

// ### tb/csw_host_model.sv
`timescale 1ns/1ns
// processor strobe and pushbutton sharing the reset line
module csw_host_model #(
	parameter int KICK_CYC = 12
) (
	input wire logic clk_in,
	input wire logic line_drv_in,
	input wire logic line_oe_n_in,
	input wire logic press_in,
	input wire logic kick_en_in,
	output logic line_level_out,
	output logic strobe_n_out
);
	int kick_cnt; // cycles since last kick

	// pin has a pull-up: low only when pulled by the device or the button
	assign line_level_out = ((!line_oe_n_in && !line_drv_in) || press_in) ? 1'b0 : 1'b1;

	// ------------------------------------------------------------
	// strobe: one low cycle each kick period, idle high otherwise
	// ------------------------------------------------------------
	initial begin
		strobe_n_out = 1'b1;
		kick_cnt = 0;
	end
	always @(negedge clk_in) begin
		kick_cnt <= kick_en_in ? (kick_cnt + 1) % KICK_CYC : 0;
		strobe_n_out <= !(kick_en_in && kick_cnt == KICK_CYC - 1);
	end
endmodule : csw_host_model

// ### tb/csw_supervisor_tb.sv
`timescale 1ns/1ns
module csw_supervisor_tb;
	localparam int TK = 4; // clocks per tick in sim
	localparam int HT = 3; // hold ticks
	localparam int DT = 3; // debounce ticks
	typedef struct {
		logic [7:0] a; // offset
		logic [7:0] d; // write data
		logic [7:0] r; // expected read back
		int p; // expected watchdog ticks, 0 none
	} csw_row_t;
	logic clk, resetn_n, supply_ok, osc_ready, press, kick_en, strobe_n, line;
	logic rst_drv, rst_oe_n, osc_run, rst_act;
	logic [7:0] rdata;
	csw_pkg::csw_reg_req_t req;
	int miscompares, samples_checked, cycles, n;
	csw_row_t rows[7] = '{'{8'h0D, 8'hFF, 8'h03, 10}, '{8'h0D, 8'h01, 8'h01, 4},
		'{8'h0D, 8'h02, 8'h02, 6}, '{8'h0D, 8'h00, 8'h00, 0}, '{8'h0B, 8'hFF, 8'h80, 0},
		'{8'h0B, 8'h00, 8'h00, 0}, '{8'h05, 8'hFF, 8'h00, 0}};

	csw_supervisor #(.TICK_CYC(TK), .HOLD_TICKS(HT), .DEB_TICKS(DT), .WD_T1(4), .WD_T2(6),
		.WD_T3(10)) csw_supervisor_inst (.clk_in(clk), .resetn_in(resetn_n), .ce_in(1'b1),
		.supply_ok_in(supply_ok), .osc_ready_in(osc_ready), .watchdog_strobe_n_in(strobe_n),
		.rst_line_in(line), .rst_line_out(rst_drv), .rst_line_oe_n_out(rst_oe_n),
		.reg_req_in(req), .reg_rdata_out(rdata), .osc_run_out(osc_run),
		.reset_active_out(rst_act));
	csw_host_model csw_host_model_inst (.clk_in(clk), .line_drv_in(rst_drv),
		.line_oe_n_in(rst_oe_n), .press_in(press), .kick_en_in(kick_en),
		.line_level_out(line), .strobe_n_out(strobe_n));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h", $time, what, got);
		end
	endtask : chk
	task automatic chk_rng(input int v, input int lo, input int hi, input string what);
		samples_checked++;
		if (v < lo || v > hi) begin
			miscompares++;
			$display("mismatch at %0t: %s took %0d cycles", $time, what, v);
		end
	endtask : chk_rng
	// count falling edges until the pin enable reaches a level
	task automatic wait_oe(input logic lvl, input int lim, output int k);
		k = 0;
		while (rst_oe_n !== lvl && k < lim) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_oe
	// optional write, then read back the same offset
	task automatic reg_acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] r);
		req = '{wr: w, addr: a, wdata: d};
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
		chk(rdata, r, "register read");
	endtask : reg_acc
	task automatic hold_len(input string what);
		wait_oe(1'b1, 40, n);
		chk_rng(n, HT * TK - 4, (HT + 1) * TK + 4, what);
	endtask : hold_len
	task automatic complete_run;
		$display("checked %0d, mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	// clock and cycle ceiling
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		resetn_n = 1'b0;
		supply_ok = 1'b1;
		osc_ready = 1'b1;
		press = 1'b0;
		kick_en = 1'b0;
		req = '{wr: 1'b0, addr: 8'h0D, wdata: 8'h00};
		repeat (4) @(negedge clk);
		chk(rst_oe_n, 1'b0, "pin pulled in reset");
		resetn_n = 1'b1;
		hold_len("power-up hold");
		wait_oe(1'b0, 14 * TK, n);
		chk_rng(n, 10 * TK - 2, 12 * TK + 3, "default watchdog");
		hold_len("watchdog hold");
		// table of register writes and resulting watchdog periods
		foreach (rows[i]) begin
			reg_acc(1'b1, rows[i].a, rows[i].d, rows[i].r);
			if (rows[i].p > 0) begin
				wait_oe(1'b0, (rows[i].p + 3) * TK, n);
				chk_rng(n, rows[i].p * TK - 3, (rows[i].p + 2) * TK + 3, "period");
				hold_len("expiry hold");
			end else if (rows[i].a == 8'h0D) begin
				repeat (60) @(negedge clk);
				chk(rst_act, 1'b0, "disabled watchdog");
			end
		end
		$display("test register rows done");
		// short press, released during debounce
		press = 1'b1;
		wait_oe(1'b0, 6, n);
		chk_rng(n, 1, 4, "press response");
		chk(rst_drv, 1'b0, "drive value");
		repeat (2) @(negedge clk);
		press = 1'b0;
		wait_oe(1'b1, 30, n);
		chk_rng(n, (DT - 1) * TK - 1, DT * TK - 2, "debounce");
		repeat (30) @(negedge clk);
		chk(rst_act, 1'b0, "no hold after short press");
		// long press held past debounce
		press = 1'b1;
		wait_oe(1'b0, 6, n);
		wait_oe(1'b1, 30, n);
		chk_rng(n, (DT - 1) * TK + 1, DT * TK, "debounce long");
		repeat (8) @(negedge clk);
		chk(rst_oe_n, 1'b1, "released while button held");
		press = 1'b0;
		wait_oe(1'b0, 6, n);
		chk_rng(n, 1, 4, "release response");
		hold_len("release hold");
		$display("test pushbutton done");
		// strobe kicks keep the shortest period alive
		reg_acc(1'b1, 8'h0D, 8'h01, 8'h01);
		kick_en = 1'b1;
		repeat (100) @(negedge clk);
		chk(rst_act, 1'b0, "kicked watchdog");
		kick_en = 1'b0;
		wait_oe(1'b0, 6 * TK, n);
		chk_rng(n, 1, 6 * TK - 1, "kick stop");
		hold_len("kick hold");
		reg_acc(1'b1, 8'h0D, 8'h00, 8'h00);
		$display("test strobe done");
		// supply loss with oscillator kept running
		supply_ok = 1'b0;
		wait_oe(1'b0, 3, n);
		chk_rng(n, 0, 2, "power fail");
		repeat (20) @(negedge clk);
		chk(rst_oe_n, 1'b0, "held in power fail");
		chk(osc_run, 1'b1, "oscillator kept");
		supply_ok = 1'b1;
		hold_len("recovery hold");
		// supply loss with oscillator stopped
		reg_acc(1'b1, 8'h0B, 8'h80, 8'h80);
		supply_ok = 1'b0;
		osc_ready = 1'b0;
		repeat (4) @(negedge clk);
		chk(osc_run, 1'b0, "oscillator stopped");
		supply_ok = 1'b1;
		repeat (40) @(negedge clk);
		chk(rst_oe_n, 1'b0, "waiting oscillator");
		osc_ready = 1'b1;
		hold_len("oscillator hold");
		$display("test power done");
		// second reset mid-run restores defaults
		resetn_n = 1'b0;
		@(negedge clk);
		chk(rst_act, 1'b1, "active in reset");
		chk(rdata, 8'h00, "read in reset");
		resetn_n = 1'b1;
		reg_acc(1'b0, 8'h0D, 8'h00, 8'h03);
		reg_acc(1'b0, 8'h0B, 8'h00, 8'h80);
		$display("test reset done");
		complete_run();
	end
endmodule : csw_supervisor_tb
